// *** dbf_map.vh ***
/*
 constants for the two-way queue port block.
 assumes inclusion by bare name from the design file.
*/
`ifndef DBF_MAP_VH
`define DBF_MAP_VH
`define DBF_DATA_W 18
`define DBF_DEPTH 512
`define DBF_ADDR_W 9
`define DBF_OFF_W 8
`define DBF_OFF_RESET 8'h80
`define DBF_HALF_LEVEL 10'h100
`define DBF_SYNC_STAGES 2
`endif

// *** dbf_ports.v ***
/*
 two-way queue ports: two queues of 18-bit words, one per direction,
 with flags, offset programming and pin-level read/write control.
 assumes one system clock well above both port clocks; port clocks,
 controls and data are asynchronous pins and are synchronised here.
*/
// Operation
// - output ready changes only on reader clock edges; the reset pin clears it without one
// - last delivered word stays while not ready
// - output ready high means head word held
// - output ready low in reset, third edge rise
// - read needs enable, select, read mode, ready
// - write needs enable, select, write mode, ready
// - data outputs off while write mode selected
// - reset: half low, ready low, almost high
// - low data byte programs offsets after reset
// - both directions behave identically
// - input ready low full/reset, second edge rise
// - half flag set at 256 or more words
// - almost flag uses offsets, default 128
// - no word stored during offset programming
`timescale 1ns/1ps
`default_nettype none
`include "dbf_map.vh"

module dbf_fifo #(
  parameter WIDTH = `DBF_DATA_W,
  parameter DEPTH = `DBF_DEPTH,
  parameter AW = `DBF_ADDR_W
) (
  input wire clock_i,
  input wire rst_i,
  input wire clear_i,
  input wire wr_edge_i,
  input wire wr_valid_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire prog_n_i,
  output wire wr_ready_o,
  input wire rd_edge_i,
  input wire rd_ready_i,
  output wire rd_valid_o,
  output wire [WIDTH-1:0] rd_data_o,
  output wire half_o,
  output wire almost_o
);
  localparam [AW:0] DEPTH_W = DEPTH;

  function [AW:0] gray_to_bin;
    input [AW:0] g;
    integer i;
    begin
      gray_to_bin[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
        gray_to_bin[i] = gray_to_bin[i+1] ^ g[i];
      end
    end
  endfunction

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wbin_reg, rbin_reg, wgray_reg, rgray_reg;
  reg [AW:0] wsync1_reg, wsync2_reg, rsync1_reg, rsync2_reg;
  reg ir_reg, or_reg, half_reg, almost_reg;
  reg [1:0] ir_start_reg;
  reg prog_open_reg, prog_second_reg;
  reg [`DBF_OFF_W-1:0] off_x_reg, off_y_reg;
  reg [WIDTH-1:0] head_reg;

  wire programming = prog_open_reg & ~prog_n_i;
  wire wr_take = wr_edge_i & wr_valid_i & ir_reg & ~programming;
  wire [AW:0] wbin_next = wbin_reg + {{AW{1'b0}}, wr_take};
  wire [AW:0] rsync_bin = gray_to_bin(rsync2_reg);
  wire [AW:0] wsync_bin = gray_to_bin(wsync2_reg);
  wire [AW:0] level = wbin_reg - rsync_bin;
  wire rd_take = rd_edge_i & rd_ready_i & or_reg;
  wire readable = rbin_reg != wsync_bin;
  wire [AW:0] rbin_inc = rbin_reg + {{AW{1'b0}}, 1'b1};

  // write side, stepped by writer clock edges
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wbin_reg <= {(AW+1){1'b0}};
      wgray_reg <= {(AW+1){1'b0}};
      rsync1_reg <= {(AW+1){1'b0}};
      rsync2_reg <= {(AW+1){1'b0}};
      ir_reg <= 1'b0;
      ir_start_reg <= 2'b00;
      prog_open_reg <= 1'b1;
      prog_second_reg <= 1'b0;
      off_x_reg <= `DBF_OFF_RESET;
      off_y_reg <= `DBF_OFF_RESET;
    end else if (clear_i) begin
      wbin_reg <= {(AW+1){1'b0}};
      wgray_reg <= {(AW+1){1'b0}};
      rsync1_reg <= {(AW+1){1'b0}};
      rsync2_reg <= {(AW+1){1'b0}};
      ir_reg <= 1'b0;
      ir_start_reg <= 2'b00;
      prog_open_reg <= 1'b1;
      prog_second_reg <= 1'b0;
      off_x_reg <= `DBF_OFF_RESET;
      off_y_reg <= `DBF_OFF_RESET;
    end else if (wr_edge_i) begin
      rsync1_reg <= rgray_reg;
      rsync2_reg <= rsync1_reg;
      ir_start_reg <= {ir_start_reg[0], 1'b1};
      ir_reg <= ir_start_reg[0] & ((wbin_next - rsync_bin) != DEPTH_W);
      if (wr_take) begin
        mem[wbin_reg[AW-1:0]] <= wr_data_i;
        wbin_reg <= wbin_next;
        wgray_reg <= wbin_next ^ (wbin_next >> 1);
        prog_open_reg <= 1'b0;
      end
      if (programming) begin
        prog_second_reg <= 1'b1;
        off_y_reg <= wr_data_i[`DBF_OFF_W-1:0];
        if (!prog_second_reg) begin
          off_x_reg <= wr_data_i[`DBF_OFF_W-1:0];
        end
      end else begin
        prog_second_reg <= 1'b0;
      end
    end
  end

  // level flags, judged from the writer's view of occupancy
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      half_reg <= 1'b0;
      almost_reg <= 1'b1;
    end else if (clear_i) begin
      half_reg <= 1'b0;
      almost_reg <= 1'b1;
    end else begin
      half_reg <= level >= `DBF_HALF_LEVEL;
      almost_reg <= (level <= {1'b0, 1'b0, off_x_reg}) ||
        (level >= DEPTH_W - {1'b0, 1'b0, off_y_reg});
    end
  end

  // read side: head word falls through on the third reader edge
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rbin_reg <= {(AW+1){1'b0}};
      rgray_reg <= {(AW+1){1'b0}};
      wsync1_reg <= {(AW+1){1'b0}};
      wsync2_reg <= {(AW+1){1'b0}};
      or_reg <= 1'b0;
      head_reg <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      rbin_reg <= {(AW+1){1'b0}};
      rgray_reg <= {(AW+1){1'b0}};
      wsync1_reg <= {(AW+1){1'b0}};
      wsync2_reg <= {(AW+1){1'b0}};
      or_reg <= 1'b0;
    end else if (rd_edge_i) begin
      wsync1_reg <= wgray_reg;
      wsync2_reg <= wsync1_reg;
      if (!or_reg || rd_take) begin
        if (readable) begin
          head_reg <= mem[rbin_reg[AW-1:0]];
          rbin_reg <= rbin_inc;
          rgray_reg <= rbin_inc ^ (rbin_inc >> 1);
          or_reg <= 1'b1;
        end else begin
          or_reg <= 1'b0;
        end
      end
    end
  end

  assign wr_ready_o = ir_reg;
  assign rd_valid_o = or_reg;
  assign rd_data_o = head_reg;
  assign half_o = half_reg;
  assign almost_o = almost_reg;
endmodule

module dbf_ports #(
  parameter WIDTH = `DBF_DATA_W,
  parameter DEPTH = `DBF_DEPTH,
  parameter AW = `DBF_ADDR_W
) (
  input wire clock_i,
  input wire rst_i,
  input wire port_a_clock_i,
  input wire port_a_select_n_i,
  input wire port_a_write_not_read_i,
  input wire port_a_write_enable_i,
  input wire port_a_read_enable_i,
  input wire [WIDTH-1:0] port_a_data_i,
  output reg [WIDTH-1:0] port_a_data_o,
  output reg port_a_data_oe_o,
  output wire port_a_output_ready_o,
  output wire port_a_input_ready_o,
  input wire port_b_clock_i,
  input wire port_b_select_n_i,
  input wire port_b_write_not_read_i,
  input wire port_b_write_enable_i,
  input wire port_b_read_enable_i,
  input wire [WIDTH-1:0] port_b_data_i,
  output reg [WIDTH-1:0] port_b_data_o,
  output reg port_b_data_oe_o,
  output wire port_b_output_ready_o,
  output wire port_b_input_ready_o,
  input wire a_to_b_reset_n_i,
  input wire b_to_a_reset_n_i,
  input wire a_to_b_offset_program_n_i,
  input wire b_to_a_offset_program_n_i,
  output wire a_to_b_half_full_o,
  output wire b_to_a_half_full_o,
  output wire a_to_b_almost_flag_o,
  output wire b_to_a_almost_flag_o
);
  localparam PW = WIDTH + 7;

  // pin bundle per port: clock, select, mode, enables, program, reset, data
  wire [PW-1:0] pins_a = {port_a_clock_i, port_a_select_n_i,
    port_a_write_not_read_i, port_a_write_enable_i, port_a_read_enable_i,
    a_to_b_offset_program_n_i, a_to_b_reset_n_i, port_a_data_i};
  wire [PW-1:0] pins_b = {port_b_clock_i, port_b_select_n_i,
    port_b_write_not_read_i, port_b_write_enable_i, port_b_read_enable_i,
    b_to_a_offset_program_n_i, b_to_a_reset_n_i, port_b_data_i};

  reg [PW-1:0] a1_reg, a2_reg, b1_reg, b2_reg;
  reg a_clk3_reg, b_clk3_reg;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      a1_reg <= {PW{1'b0}};
      a2_reg <= {PW{1'b0}};
      b1_reg <= {PW{1'b0}};
      b2_reg <= {PW{1'b0}};
      a_clk3_reg <= 1'b0;
      b_clk3_reg <= 1'b0;
    end else begin
      a1_reg <= pins_a;
      a2_reg <= a1_reg;
      b1_reg <= pins_b;
      b2_reg <= b1_reg;
      a_clk3_reg <= a2_reg[PW-1];
      b_clk3_reg <= b2_reg[PW-1];
    end
  end

  wire a_edge = a2_reg[PW-1] & ~a_clk3_reg;
  wire b_edge = b2_reg[PW-1] & ~b_clk3_reg;
  wire a_sel = ~a2_reg[PW-2];
  wire b_sel = ~b2_reg[PW-2];
  wire a_wnr = a2_reg[PW-3];
  wire b_wnr = b2_reg[PW-3];
  wire a_wr = a_sel & a_wnr & a2_reg[PW-4];
  wire b_wr = b_sel & b_wnr & b2_reg[PW-4];
  wire a_rd = a_sel & ~a_wnr & a2_reg[PW-5];
  wire b_rd = b_sel & ~b_wnr & b2_reg[PW-5];
  // reset level acts on both queue ends; held across both clocks
  wire ab_clear = ~a2_reg[PW-7];
  wire ba_clear = ~b2_reg[PW-7];
  wire a_or, b_or;
  wire [WIDTH-1:0] ab_head, ba_head;

  dbf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) queue_a_to_b (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(ab_clear),
    .wr_edge_i(a_edge),
    .wr_valid_i(a_wr),
    .wr_data_i(a2_reg[WIDTH-1:0]),
    .prog_n_i(a2_reg[PW-6]),
    .wr_ready_o(port_a_input_ready_o),
    .rd_edge_i(b_edge),
    .rd_ready_i(b_rd),
    .rd_valid_o(b_or),
    .rd_data_o(ab_head),
    .half_o(a_to_b_half_full_o),
    .almost_o(a_to_b_almost_flag_o)
  );

  dbf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) queue_b_to_a (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(ba_clear),
    .wr_edge_i(b_edge),
    .wr_valid_i(b_wr),
    .wr_data_i(b2_reg[WIDTH-1:0]),
    .prog_n_i(b2_reg[PW-6]),
    .wr_ready_o(port_b_input_ready_o),
    .rd_edge_i(a_edge),
    .rd_ready_i(a_rd),
    .rd_valid_o(a_or),
    .rd_data_o(ba_head),
    .half_o(b_to_a_half_full_o),
    .almost_o(b_to_a_almost_flag_o)
  );

  assign port_a_output_ready_o = a_or;
  assign port_b_output_ready_o = b_or;

  // data pins: drive only in read mode, hold last word read
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_data_o <= {WIDTH{1'b0}};
      port_b_data_o <= {WIDTH{1'b0}};
      port_a_data_oe_o <= 1'b0;
      port_b_data_oe_o <= 1'b0;
    end else begin
      port_a_data_oe_o <= a_sel & ~a_wnr;
      port_b_data_oe_o <= b_sel & ~b_wnr;
      if (a_edge & a_rd & a_or) begin
        port_a_data_o <= ba_head;
      end
      if (b_edge & b_rd & b_or) begin
        port_b_data_o <= ab_head;
      end
    end
  end
endmodule
`default_nettype wire

// *** dbf_master.sv ***
/* far-side host model for one port: free-running port clock and
   resolved data pins. assumes the bench drives the host controls. */
`timescale 1ns/1ps
`default_nettype none
module dbf_master #(
  parameter int HALF = 4
) (
  input wire logic clock_i,
  input wire logic [17:0] dev_data_i,
  input wire logic dev_oe_i,
  input wire logic [17:0] host_data_i,
  input wire logic host_en_i,
  output var logic port_clock_o,
  output wire logic [17:0] bus_o
);
  int cnt = 0;
  logic [17:0] last_reg = 18'h0_0000;
  initial port_clock_o = 1'b0;
  // port clock runs free, as a host clock does
  always @(negedge clock_i) begin
    cnt = (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == 0) port_clock_o <= ~port_clock_o;
    last_reg <= bus_o;
  end
  // host drives only in write mode; undriven pins toggle
  assign bus_o = dev_oe_i ? dev_data_i :
    host_en_i ? host_data_i : ~last_reg;
endmodule
`default_nettype wire

// *** dbf_ports_assertions.sv ***
/* checker for the two-way queue ports.
   assumes bind onto dbf_ports and the system clock domain only. */
`timescale 1ns/1ps
`default_nettype none
module dbf_ports_chk #(
  parameter WIDTH = 18
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic port_a_clock_i,
  input wire logic port_a_select_n_i,
  input wire logic port_a_write_not_read_i,
  input wire logic port_a_data_oe_o,
  input wire logic port_a_input_ready_o,
  input wire logic port_a_output_ready_o,
  input wire logic port_b_clock_i,
  input wire logic port_b_write_not_read_i,
  input wire logic [WIDTH-1:0] port_b_data_o,
  input wire logic port_b_data_oe_o,
  input wire logic port_b_output_ready_o,
  input wire logic port_b_input_ready_o,
  input wire logic a_to_b_reset_n_i,
  input wire logic b_to_a_reset_n_i,
  input wire logic a_to_b_half_full_o,
  input wire logic a_to_b_almost_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence ab_held; !a_to_b_reset_n_i [*5]; endsequence
  sequence ba_held; !b_to_a_reset_n_i [*5]; endsequence
  a_oe_off_a: assert property (port_a_write_not_read_i [*5]
    |-> !port_a_data_oe_o) else $error("port a drives in write mode");
  a_oe_off_b: assert property (port_b_write_not_read_i [*5]
    |-> !port_b_data_oe_o) else $error("port b drives in write mode");
  a_oe_on_a: assert property (
    (!port_a_select_n_i && !port_a_write_not_read_i) [*5]
    |-> port_a_data_oe_o) else $error("port a not driving on read");
  a_ab_reset: assert property (ab_held |-> !port_a_input_ready_o &&
    !port_b_output_ready_o && !a_to_b_half_full_o && a_to_b_almost_flag_o)
    else $error("a to b flags wrong in reset");
  a_ba_reset: assert property (ba_held |->
    !port_b_input_ready_o && !port_a_output_ready_o)
    else $error("b to a flags wrong in reset");
  a_or_edge_b: assert property ($rose(port_b_output_ready_o)
    |-> $past(port_b_clock_i, 2)) else $error("port b ready off edge");
  a_ir_edge_a: assert property ($rose(port_a_input_ready_o)
    |-> $past(port_a_clock_i, 2)) else $error("port a input off edge");
  a_hold_b: assert property (!port_b_output_ready_o [*3]
    |=> $stable(port_b_data_o)) else $error("port b data not held");
endmodule
bind dbf_ports dbf_ports_chk #(.WIDTH(WIDTH)) dbf_ports_chk_i (
  .clock_i, .rst_i, .port_a_clock_i, .port_a_select_n_i,
  .port_a_write_not_read_i, .port_a_data_oe_o, .port_a_input_ready_o,
  .port_a_output_ready_o, .port_b_clock_i, .port_b_write_not_read_i,
  .port_b_data_o, .port_b_data_oe_o, .port_b_output_ready_o,
  .port_b_input_ready_o, .a_to_b_reset_n_i, .b_to_a_reset_n_i,
  .a_to_b_half_full_o, .a_to_b_almost_flag_o);
`default_nettype wire

// *** tb.sv ***
/* bench for the two-way queue ports: reset, offsets, fill and drain.
   assumes dbf_master models both hosts; depth shrunk to 16. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic clock_i = 0, rst_i = 1;
  logic [1:0] sn = 2'b11, wr = 0, we = 0, re = 0, rn = 0, pn = 2'b11;
  logic [17:0] hd [2] = '{default: 18'h0_0000};
  logic [17:0] last [2];
  logic [17:0] q [2][$];
  wire [17:0] bus [2];
  wire [17:0] dout [2];
  wire [1:0] pc, oe, ir, orr;
  wire hab, hba, aab, aba;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  initial forever #50 clock_i = ~clock_i;
  dbf_ports #(.DEPTH(16), .AW(4)) dbf_ports_i (.clock_i, .rst_i,
    .port_a_clock_i(pc[0]), .port_a_select_n_i(sn[0]),
    .port_a_write_not_read_i(wr[0]), .port_a_write_enable_i(we[0]),
    .port_a_read_enable_i(re[0]), .port_a_data_i(bus[0]),
    .port_a_data_o(dout[0]), .port_a_data_oe_o(oe[0]),
    .port_a_output_ready_o(orr[0]), .port_a_input_ready_o(ir[0]),
    .port_b_clock_i(pc[1]), .port_b_select_n_i(sn[1]),
    .port_b_write_not_read_i(wr[1]), .port_b_write_enable_i(we[1]),
    .port_b_read_enable_i(re[1]), .port_b_data_i(bus[1]),
    .port_b_data_o(dout[1]), .port_b_data_oe_o(oe[1]),
    .port_b_output_ready_o(orr[1]), .port_b_input_ready_o(ir[1]),
    .a_to_b_reset_n_i(rn[0]), .b_to_a_reset_n_i(rn[1]),
    .a_to_b_offset_program_n_i(pn[0]), .b_to_a_offset_program_n_i(pn[1]),
    .a_to_b_half_full_o(hab), .b_to_a_half_full_o(hba),
    .a_to_b_almost_flag_o(aab), .b_to_a_almost_flag_o(aba));
  for (genvar p = 0; p < 2; p++) begin : g
    logic [17:0] e;
    dbf_master #(.HALF(4 + 3 * p)) dbf_master_i (.clock_i,
      .dev_data_i(dout[p]), .dev_oe_i(oe[p]), .host_data_i(hd[p]),
      .host_en_i(wr[p]), .port_clock_o(pc[p]), .bus_o(bus[p]));
    // read result lands a few system clocks after the port edge
    always @(posedge pc[p])
      if (!sn[p] && !wr[p] && re[p] && orr[p] === 1'b1) begin
        repeat (6) @(posedge clock_i);
        #1 e = q[p].pop_front();
        last[p] = e;
        `CHK("read data", e, dout[p])
      end
  end
  task automatic xfer(int p, bit w, bit pg, logic [17:0] d,
                      output bit ok);
    @(negedge pc[p]);
    sn[p] = 0; wr[p] = w; we[p] = w; re[p] = !w; pn[p] = !pg; hd[p] = d;
    @(posedge pc[p]);
    ok = w ? ir[p] : orr[p];
    if (ok && w && !pg) q[1-p].push_back(d);
  endtask
  task automatic idle(int p);
    @(negedge pc[p]);
    sn[p] = 1; wr[p] = 0; we[p] = 0; re[p] = 0; pn[p] = 1;
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 20000) begin
    error_cnt++;
    report_and_stop;
  end
  initial begin
    bit ok;
    void'($urandom(92334));
    repeat (3) @(posedge clock_i);
    @(negedge clock_i) rst_i = 0;
    for (int p = 0; p < 2; p++) begin
      repeat (5) @(posedge pc[1]);
      @(negedge pc[p]);
      rn[p] = 1;
      @(posedge pc[p]);
      repeat (6) @(posedge clock_i);
      `CHK("input ready", 1'b0, ir[p])
      @(posedge pc[p]);
      repeat (6) @(posedge clock_i);
      `CHK("input ready", 1'b1, ir[p])
    end
    `CHK("almost", 1'b1, aab)
    `CHK("half", 1'b0, hab)
    `CHK("almost b", 1'b1, aba)
    `CHK("half b", 1'b0, hba)
    xfer(0, 1, 1, 18'h0_0001, ok);
    @(posedge pc[1]);
    xfer(0, 1, 0, 18'($urandom), ok);
    fork idle(0); join_none
    repeat (2) @(posedge pc[1]);
    repeat (6) @(posedge clock_i);
    `CHK("ready early", 1'b0, orr[1])
    @(posedge pc[1]);
    repeat (6) @(posedge clock_i);
    `CHK("ready", 1'b1, orr[1])
    repeat (3) xfer(0, 1, 0, 18'($urandom), ok);
    idle(0);
    repeat (40) @(posedge clock_i);
    `CHK("almost", 1'b0, aab)
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 40 && ok; i++) xfer(p, 1, 0, 18'($urandom), ok);
      `CHK("full refused", 1'b0, ok)
      idle(p);
      repeat (q[1-p].size() + 2) xfer(1 - p, 0, 0, 18'h0_0000, ok);
      `CHK("empty refused", 1'b0, ok)
      idle(1 - p);
      repeat (20) @(posedge clock_i);
      `CHK("held", last[1-p], dout[1-p])
      `CHK("left", 0, q[1-p].size())
      ok = 1;
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
